//--- src/acs_pkg.sv
package acs_pkg;

   // ==========================================================================
   // register offsets
   localparam logic [7:0]  CTRL_ONE_OFS     = 8'h00;
   localparam logic [7:0]  CTRL_THREE_OFS   = 8'h04;
   localparam logic [7:0]  CHAN_SEL_OFS     = 8'h08;
   localparam logic [7:0]  SW_TRIG_OFS      = 8'h0c;
   localparam logic [7:0]  INT_STATUS_OFS   = 8'h10;
   localparam logic [7:0]  INT_MASK_OFS     = 8'h14;
   localparam logic [7:0]  STATE_OFS        = 8'h18;
   localparam logic [7:0]  RESULT_BASE_OFS  = 8'h40;

   // ==========================================================================
   // field positions and widths
   localparam int          ACQPS_LSB        = 8;
   localparam int          ACQPS_W          = 4;
   localparam int          CONT_BIT         = 4;
   localparam int          REF_EN_HI_BIT    = 7;
   localparam int          REF_EN_LO_BIT    = 6;
   localparam int          PWR_BIT          = 5;
   localparam int          MODE_BIT         = 0;
   localparam int          SW_TRIG_BIT      = 0;
   localparam int          CHAN_W           = 4;
   localparam int          NUM_CHAN         = 16;
   localparam int          RES_W            = 12;
   localparam int          INT_W            = 2;
   localparam int          INT_RES_BIT      = 0;
   localparam int          INT_IGN_BIT      = 1;
   localparam int          ST_BUSY_BIT      = 0;
   localparam int          ST_REF_BIT       = 1;
   localparam int          ST_PWR_BIT       = 2;
   localparam int          ST_CHAN_LSB      = 4;

   // ==========================================================================
   // reset values
   localparam logic [ACQPS_W-1:0] ACQPS_RST = 4'h0;
   localparam logic [CHAN_W-1:0]  CHAN_RST  = 4'h0;
   localparam logic [INT_W-1:0]   INT_RST   = 2'h0;

   // ==========================================================================
   // timing
   localparam int          PCLK_PERIOD_NS   = 5;
   localparam int          CONV_CLK_DIV     = 8;
   localparam int          SAMP_DLY_HALVES  = 5;
   localparam int          FIRST_RES_CLKS   = 4;
   localparam int          GAP_CLKS         = 1;
   localparam int          INT_DELAY_CYC    = 2;
   localparam int          REF_SETTLE_NS    = 5000000;
   localparam int          PWR_SETTLE_NS    = 1000000;
   localparam int          REF_SETTLE_CYC   = REF_SETTLE_NS / PCLK_PERIOD_NS;
   localparam int          PWR_SETTLE_CYC   = PWR_SETTLE_NS / PCLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ACS_IDLE,
      ACS_DELAY,
      ACS_HOLD,
      ACS_GAP
   } acs_state_t;

endpackage : acs_pkg

//--- src/acs_result_mem.sv
`timescale 1ns/10ps
module acs_result_mem
   import acs_pkg::*;
#(
   parameter int DEPTH = NUM_CHAN,
   parameter int WIDTH = RES_W
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]         wr_data,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic      [WIDTH-1:0]         rd_data
);

   logic [WIDTH-1:0] mem_reg [DEPTH];

   // ==========================================================================
   // storage, read data registered
   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem_reg[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_reg[rd_addr];
      end
   end

endmodule : acs_result_mem

//--- src/acs_ctrl.sv
`timescale 1ns/10ps
module acs_ctrl
   import acs_pkg::*;
#(
   parameter int CLK_DIV    = CONV_CLK_DIV,
   parameter int REF_SETTLE = REF_SETTLE_CYC,
   parameter int PWR_SETTLE = PWR_SETTLE_CYC
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              pwm_trigger,
   input  wire logic              external_conversion_start,
   input  wire logic [RES_W-1:0]  core_data,
   output logic                   sample_hold,
   output logic                   sample_pair,
   output logic      [CHAN_W-1:0] sample_channel,
   output logic                   reference_power_enables_hi,
   output logic                   reference_power_enables_lo,
   output logic                   converter_power_bit,
   output logic                   irq
);

   localparam int CW       = 10;
   localparam int SAMP_DLY = SAMP_DLY_HALVES * CLK_DIV / 2;
   localparam int LAT_CYC  = FIRST_RES_CLKS * CLK_DIV;
   localparam int LAT_M1   = LAT_CYC - 1;
   localparam int INT_SEEN = INT_DELAY_CYC + 1;
   localparam int PW       = 1 + 1 + CHAN_W + RES_W;
   localparam int RW       = $clog2(REF_SETTLE + 1);
   localparam int QW       = $clog2(PWR_SETTLE + 1);

   function automatic logic [CW-1:0] hold_cycles(input logic [ACQPS_W-1:0] acq);
      hold_cycles = CW'((int'(acq) + 1) * CLK_DIV);
   endfunction : hold_cycles

   function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] ofs);
      is_reg = (addr == ofs);
   endfunction : is_reg

   // ==========================================================================
   // registers
   logic [ACQPS_W-1:0] acqps_reg;
   logic               cont_reg;
   logic               ref_hi_reg;
   logic               ref_lo_reg;
   logic               pwr_reg;
   logic               mode_reg;
   logic [CHAN_W-1:0]  chan_reg;
   logic [INT_W-1:0]   int_status_reg;
   logic [INT_W-1:0]   int_status_next;
   logic [INT_W-1:0]   int_mask_reg;
   logic [RW-1:0]      ref_cnt_reg;
   logic [QW-1:0]      pwr_cnt_reg;
   acs_state_t         state_reg;
   acs_state_t         state_next;
   logic [CW-1:0]      cnt_reg;
   logic [CW-1:0]      cnt_next;
   logic [ACQPS_W-1:0] acqps_lat_reg;
   logic [CHAN_W-1:0]  ch_lat_reg;
   logic               follow_reg;
   logic               ext_prev_reg;
   logic [CHAN_W-1:0]  last_ch_reg;
   logic [INT_DELAY_CYC-1:0] int_dly_reg;
   logic [PW-1:0]      pipe_reg [LAT_CYC];
   logic [RES_W-1:0]   mem_rdata;

   // ==========================================================================
   // bus decode
   wire         wr_acc    = psel & penable & pwrite;
   wire         rd_acc    = psel & penable & ~pwrite;
   wire         hit_one   = is_reg(paddr, CTRL_ONE_OFS);
   wire         hit_three = is_reg(paddr, CTRL_THREE_OFS);
   wire         hit_chan  = is_reg(paddr, CHAN_SEL_OFS);
   wire         hit_sw    = is_reg(paddr, SW_TRIG_OFS);
   wire         hit_stat  = is_reg(paddr, INT_STATUS_OFS);
   wire         hit_mask  = is_reg(paddr, INT_MASK_OFS);
   wire         hit_state = is_reg(paddr, STATE_OFS);
   wire         hit_res   = (paddr[7:6] == RESULT_BASE_OFS[7:6]) && (paddr[1:0] == 2'h0);
   wire         mapped    = hit_one | hit_three | hit_chan | hit_sw | hit_stat | hit_mask
                            | hit_state | hit_res;
   wire [CHAN_W-1:0] res_idx = paddr[5:2];

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // ==========================================================================
   // triggers and sequencer decode
   wire         ext_rise  = external_conversion_start & ~ext_prev_reg;
   wire         sw_trig   = wr_acc & hit_sw & pwdata[SW_TRIG_BIT];
   wire         any_trig  = pwm_trigger | ext_rise | sw_trig;
   wire         is_idle   = (state_reg == ACS_IDLE);
   wire         trig_acc  = any_trig & pwr_reg & is_idle;
   wire         ign_evt   = any_trig & ~trig_acc;
   wire         cnt_done  = (cnt_reg == '0);
   wire         capture   = (state_reg == ACS_HOLD) & cnt_done & pwr_reg;
   wire [PW-1:0] pipe_in  = {capture, follow_reg, ch_lat_reg, core_data};
   wire [PW-1:0] pipe_out = pipe_reg[LAT_CYC-1];
   wire         res_we    = pipe_out[PW-1];
   wire         res_follow = pipe_out[PW-2];
   wire [CHAN_W-1:0] res_ch = pipe_out[RES_W +: CHAN_W];
   wire [RES_W-1:0] res_dat = pipe_out[RES_W-1:0];
   wire         ref_ready = (ref_cnt_reg == RW'(REF_SETTLE));
   wire         pwr_ready = (pwr_cnt_reg == QW'(PWR_SETTLE));
   wire         busy      = ~is_idle;

   assign sample_hold    = (state_reg == ACS_HOLD);
   assign sample_pair    = sample_hold & mode_reg;
   assign sample_channel = ch_lat_reg;
   assign reference_power_enables_hi = ref_hi_reg;
   assign reference_power_enables_lo = ref_lo_reg;
   assign converter_power_bit        = pwr_reg;
   assign irq = |(int_status_reg & int_mask_reg);

   // ==========================================================================
   // read mux
   wire [31:0] rd_one   = {20'h0, acqps_reg, 3'h0, cont_reg, 4'h0};
   wire [31:0] rd_three = {24'h0, ref_hi_reg, ref_lo_reg, pwr_reg, 4'h0, mode_reg};
   wire [31:0] rd_state = {24'h0, last_ch_reg, 1'b0, pwr_ready, ref_ready, busy};
   assign prdata = hit_one   ? rd_one :
                   hit_three ? rd_three :
                   hit_chan  ? {28'h0, chan_reg} :
                   hit_stat  ? {30'h0, int_status_reg} :
                   hit_mask  ? {30'h0, int_mask_reg} :
                   hit_state ? rd_state :
                   hit_res   ? {20'h0, mem_rdata} : 32'h0;

   // ==========================================================================
   // control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acqps_reg  <= ACQPS_RST;
         cont_reg   <= 1'b0;
         ref_hi_reg <= 1'b0;
         ref_lo_reg <= 1'b0;
         pwr_reg    <= 1'b0;
         mode_reg   <= 1'b0;
         chan_reg   <= CHAN_RST;
         int_mask_reg <= INT_RST;
      end else if (wr_acc) begin
         if (hit_one) begin
            acqps_reg <= pwdata[ACQPS_LSB +: ACQPS_W];
            cont_reg  <= pwdata[CONT_BIT];
         end
         if (hit_three) begin
            ref_hi_reg <= pwdata[REF_EN_HI_BIT];
            ref_lo_reg <= pwdata[REF_EN_LO_BIT];
            pwr_reg    <= pwdata[PWR_BIT];
            mode_reg   <= pwdata[MODE_BIT];
         end
         if (hit_chan) begin
            chan_reg <= pwdata[CHAN_W-1:0];
         end
         if (hit_mask) begin
            int_mask_reg <= pwdata[INT_W-1:0];
         end
      end
   end

   // ==========================================================================
   // settle timers shown in state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_cnt_reg <= '0;
         pwr_cnt_reg <= '0;
      end else begin
         ref_cnt_reg <= !(ref_hi_reg & ref_lo_reg) ? '0 :
                        ref_ready ? ref_cnt_reg : ref_cnt_reg + 1'b1;
         pwr_cnt_reg <= !pwr_reg ? '0 : pwr_ready ? pwr_cnt_reg : pwr_cnt_reg + 1'b1;
      end
   end

   // ==========================================================================
   // sample sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_done ? cnt_reg : cnt_reg - 1'b1;
      unique case (state_reg)
         ACS_IDLE: begin
            if (trig_acc) begin
               state_next = ACS_DELAY;
               cnt_next   = CW'(SAMP_DLY - 2);
            end
         end
         ACS_DELAY: begin
            if (cnt_done) begin
               state_next = ACS_HOLD;
               cnt_next   = hold_cycles(acqps_lat_reg) - 1'b1;
            end
         end
         ACS_HOLD: begin
            if (cnt_done) begin
               state_next = cont_reg ? ACS_GAP : ACS_IDLE;
               cnt_next   = CW'(GAP_CLKS * CLK_DIV - 1);
            end
         end
         ACS_GAP: begin
            if (cnt_done) begin
               state_next = ACS_HOLD;
               cnt_next   = hold_cycles(acqps_lat_reg) - 1'b1;
            end
         end
      endcase
      if (!pwr_reg) begin
         state_next = ACS_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg     <= ACS_IDLE;
         cnt_reg       <= '0;
         acqps_lat_reg <= ACQPS_RST;
         ch_lat_reg    <= CHAN_RST;
         follow_reg    <= 1'b0;
         ext_prev_reg  <= 1'b0;
      end else begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         ext_prev_reg <= external_conversion_start;
         if (trig_acc) begin
            acqps_lat_reg <= acqps_reg;
         end
         if (state_next == ACS_HOLD && !sample_hold) begin
            ch_lat_reg <= chan_reg;
            follow_reg <= (state_reg == ACS_GAP);
         end
      end
   end

   // ==========================================================================
   // result latency line
   generate
      for (genvar i = 0; i < LAT_CYC; i++) begin : g_pipe
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pipe_reg[i] <= '0;
            end else begin
               pipe_reg[i] <= (i == 0) ? pipe_in : pipe_reg[(i == 0) ? 0 : i - 1];
            end
         end
      end
   endgenerate

   acs_result_mem #(
      .DEPTH (NUM_CHAN),
      .WIDTH (RES_W)
   ) u_mem (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (res_we),
      .wr_addr (res_ch),
      .wr_data (res_dat),
      .rd_addr (res_idx),
      .rd_data (mem_rdata)
   );

   // ==========================================================================
   // interrupt status, read clears, set wins
   always_comb begin
      int_status_next = int_status_reg;
      if (rd_acc && hit_stat) begin
         int_status_next = INT_RST;
      end
      if (int_dly_reg[INT_DELAY_CYC-1]) begin
         int_status_next[INT_RES_BIT] = 1'b1;
      end
      if (ign_evt) begin
         int_status_next[INT_IGN_BIT] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status_reg <= INT_RST;
         int_dly_reg    <= '0;
         last_ch_reg    <= CHAN_RST;
      end else begin
         int_status_reg <= int_status_next;
         int_dly_reg    <= {int_dly_reg[INT_DELAY_CYC-2:0], res_we};
         if (res_we) begin
            last_ch_reg <= res_ch;
         end
      end
   end

   // ==========================================================================
   // checks
   logic [CW-1:0] sh_len_reg;
   logic [CW-1:0] gap_len_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_len_reg  <= '0;
         gap_len_reg <= '0;
      end else begin
         sh_len_reg  <= sample_hold ? sh_len_reg + 1'b1 : '0;
         gap_len_reg <= res_we ? CW'(1) : (&gap_len_reg) ? gap_len_reg : gap_len_reg + 1'b1;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   trig_to_sample_a: assert property (trig_acc |-> ##SAMP_DLY $rose(sample_hold))
      else $error("sample pulse not at trigger delay");
   sh_width_a: assert property ($fell(sample_hold) && pwr_reg
      |-> sh_len_reg == hold_cycles(acqps_lat_reg))
      else $error("sample pulse width wrong");
   first_result_a: assert property ($fell(sample_hold) && pwr_reg
      |-> ##LAT_M1 res_we)
      else $error("result not written at latency");
   next_result_a: assert property (res_we && res_follow
      |-> gap_len_reg == hold_cycles(acqps_lat_reg) + CW'(GAP_CLKS * CLK_DIV))
      else $error("successive result spacing wrong");
   flag_after_a: assert property (res_we
      |-> ##INT_SEEN int_status_reg[INT_RES_BIT])
      else $error("result flag not raised");
   flag_not_early_a: assert property (res_we && !int_status_reg[INT_RES_BIT]
      && !int_dly_reg[0] && !int_dly_reg[1] |=> !int_status_reg[INT_RES_BIT])
      else $error("result flag raised before write");
   power_gate_a: assert property (!pwr_reg |=> !sample_hold)
      else $error("sample pulse without power");
   chan_stable_a: assert property (sample_hold && $past(sample_hold)
      |-> $stable(sample_channel))
      else $error("channel moved during sample pulse");
   pair_mode_a: assert property (sample_pair |-> mode_reg && sample_hold)
      else $error("pair sampling outside mode one");
   capture_a: assert property (capture |=> pipe_reg[0][RES_W-1:0] == $past(core_data))
      else $error("sample not captured at pulse end");

   run_c: cover property (res_we && res_follow);
   ignore_c: cover property (ign_evt && !pwr_reg);
   long_pulse_c: cover property ($fell(sample_hold) && acqps_lat_reg == 4'hf);
   irq_c: cover property ($rose(irq));

endmodule : acs_ctrl

//--- bench/acs_core_model.sv
`timescale 1ns/10ps
// ========================================
// analog core model
module acs_core_model
   import acs_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              sample_hold,
   input  wire logic [CHAN_W-1:0] sample_channel,
   output logic      [RES_W-1:0]  core_data
);
   logic [RES_W-1:0] idle_reg = 12'h5a5;
   // bus changes every cycle outside the pulse
   always @(posedge pclk) idle_reg <= ~idle_reg;
   // twelve bit code of the held channel
   assign core_data = sample_hold ? {4'h9, sample_channel, ~sample_channel}
                                  : idle_reg;
endmodule : acs_core_model

//--- bench/adc_powerup_and_sequential_sampling_bench.sv
`timescale 1ns/10ps
module adc_powerup_and_sequential_sampling_bench;
   import acs_pkg::*;
   localparam int   CLK_DIV = CONV_CLK_DIV;
   logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic             pwm_trigger, ext_start, sample_hold, sample_pair, irq, err;
   logic             ref_hi, ref_lo, pwr;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata, rd;
   logic [RES_W-1:0] core_data;
   logic [3:0]       sample_channel;
   int               error_cnt = 0;
   int               checks_done = 0;

   acs_ctrl #(.CLK_DIV(CLK_DIV), .REF_SETTLE(20), .PWR_SETTLE(10)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pwm_trigger(pwm_trigger),
      .external_conversion_start(ext_start), .core_data(core_data),
      .sample_hold(sample_hold), .sample_pair(sample_pair),
      .sample_channel(sample_channel), .reference_power_enables_hi(ref_hi),
      .reference_power_enables_lo(ref_lo), .converter_power_bit(pwr), .irq(irq));

   acs_core_model u_core (
      .pclk(pclk), .sample_hold(sample_hold),
      .sample_channel(sample_channel), .core_data(core_data));

   // ========================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic trig(input int src);
      if (src == 2)
         apb(1'b1, SW_TRIG_OFS, 32'h1);
      else begin
         pwm_trigger <= (src == 0);
         ext_start   <= (src == 1);
         @(posedge pclk);
         pwm_trigger <= 1'b0;
         ext_start   <= 1'b0;
      end
   endtask : trig

   task automatic wait_sh(input logic v, output int n);
      n = 0;
      while (sample_hold !== v && n < 400) begin
         @(posedge pclk);
         n++;
      end
   endtask : wait_sh

   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim

   // ========================================
   // scenarios
   task automatic t_regs;
      apb(1'b0, CTRL_THREE_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, INT_MASK_OFS, 32'h3);
      apb(1'b0, INT_MASK_OFS, 32'h0);
      chk(rd, 32'h3);
      $display("t_regs done");
   endtask : t_regs

   task automatic t_gate;
      int n;
      trig(0);
      wait_sh(1'b1, n);
      chk(n, 400);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, INT_STATUS_OFS, 32'h0);
      chk({30'h0, rd[1:0]}, 32'h2);
      chk({31'h0, irq}, 32'h0);
      $display("t_gate done");
   endtask : t_gate

   task automatic t_power;
      apb(1'b1, CTRL_THREE_OFS, 32'hc0);
      repeat (25) @(posedge pclk);
      apb(1'b0, STATE_OFS, 32'h0);
      chk({30'h0, rd[2:1]}, 32'h1);
      apb(1'b1, CTRL_THREE_OFS, 32'he0);
      chk({29'h0, ref_hi, ref_lo, pwr}, 32'h7);
      repeat (15) @(posedge pclk);
      apb(1'b0, STATE_OFS, 32'h0);
      chk({30'h0, rd[2:1]}, 32'h3);
      apb(1'b1, CTRL_THREE_OFS, 32'h0);
      apb(1'b1, CTRL_THREE_OFS, 32'he0);
      apb(1'b0, STATE_OFS, 32'h0);
      chk({30'h0, rd[2:1]}, 32'h0);
      repeat (25) @(posedge pclk);
      apb(1'b0, STATE_OFS, 32'h0);
      chk({30'h0, rd[2:1]}, 32'h3);
      $display("t_power done");
   endtask : t_power

   task automatic t_seq(input int src, input logic [3:0] a, input logic [3:0] ch);
      int n, w, f;
      apb(1'b1, CTRL_ONE_OFS, {20'h0, a, 8'h0});
      apb(1'b1, CHAN_SEL_OFS, {28'h0, ch});
      trig(src);
      wait_sh(1'b1, n);
      chk(n + (src == 2), SAMP_DLY_HALVES * CLK_DIV / 2);
      chk({28'h0, sample_channel}, {28'h0, ch});
      chk({31'h0, sample_pair}, 32'h0);
      wait_sh(1'b0, w);
      chk(w, (1 + a) * CLK_DIV);
      f = 0;
      while (irq !== 1'b1 && f < 100) begin
         @(posedge pclk);
         f++;
      end
      chk({31'h0, f >= 4 * CLK_DIV && f <= 5 * CLK_DIV}, 32'h1);
      apb(1'b0, RESULT_BASE_OFS + {2'h0, ch, 2'h0}, 32'h0);
      chk(rd, {20'h0, 4'h9, ch, ~ch});
      apb(1'b0, INT_STATUS_OFS, 32'h0);
      chk({31'h0, rd[0]}, 32'h1);
      $display("t_seq done");
   endtask : t_seq

   task automatic t_cont;
      int n, p, q;
      apb(1'b1, CTRL_ONE_OFS, 32'h110);
      apb(1'b1, CHAN_SEL_OFS, 32'h9);
      trig(0);
      wait_sh(1'b1, n);
      wait_sh(1'b0, p);
      wait_sh(1'b1, q);
      chk(p + q, 3 * CLK_DIV);
      apb(1'b1, CTRL_ONE_OFS, 32'h100);
      repeat (100) @(posedge pclk);
      apb(1'b0, RESULT_BASE_OFS + 8'h24, 32'h0);
      chk(rd, 32'h996);
      apb(1'b0, INT_STATUS_OFS, 32'h0);
      $display("t_cont done");
   endtask : t_cont

   task automatic t_mode;
      int n;
      apb(1'b1, CTRL_THREE_OFS, 32'he1);
      trig(0);
      wait_sh(1'b1, n);
      chk({31'h0, sample_pair}, 32'h1);
      repeat (80) @(posedge pclk);
      apb(1'b0, INT_STATUS_OFS, 32'h0);
      apb(1'b1, CTRL_THREE_OFS, 32'he0);
      $display("t_mode done");
   endtask : t_mode

   // ========================================
   // clock, reset, sequence, watchdog
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   initial begin
      {presetn, psel, penable, pwrite, pwm_trigger, ext_start} = 6'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_gate();
      t_power();
      t_seq(0, 4'h0, 4'h5);
      t_seq(1, 4'hf, 4'hf);
      t_seq(2, 4'h3, 4'h0);
      t_cont();
      t_mode();
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      end_sim();
   end
endmodule : adc_powerup_and_sequential_sampling_bench
